/* File: logic/pwm_guard.sv */
/*
 * PWM output stage with auto-shutdown, restart on period boundary and
 * half-bridge dead-band, reached over APB with an interrupt.
 * Assumes comparator and pin inputs are asynchronous to clock; pads
 * combine out, enable (low drives) into the four bridge pins.
 */
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pwm_guard_consts.svh"
// Behaviour
// R01 - event flag reads 1 while outputs held in shutdown, 0 when normal
// R02 - three-bit source select ORs comparator one, comparator two, low interrupt pin
// R03 - pair A/C shutdown state: 00 low, 01 high, 1x float
// R04 - pair B/D shutdown state: 00 low, 01 high, 1x float
// R05 - shutdown is level sensitive and lasts while any enabled source holds
// R06 - software writes to event flag ignored while a condition holds
// R07 - after restart outputs resume only at start of next period
// R08 - auto-restart on: hardware clears flag once condition goes away
// R09 - auto-restart off: software must clear the flag to restart
// R10 - dead-band only delays inactive-to-active edges
// R11 - seven-bit count of instruction cycles, each four oscillator periods
// R12 - auto-restart is bit 7 beside delay count, both reset to zero
// R13 - pins go to shutdown state at once, no period wait
// R14 - software writing 1 to event flag is itself a shutdown event
// R15 - delay longer than duty keeps output inactive whole cycle
// R16 - half-bridge: A carries PWM, B its complement, both delayed
// R17 - delay counter restarts on every scheduled rising edge
module pwm_guard
    import pwm_guard_pkg::*;
#(
    parameter int DELAY_WIDTH = 7
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparatorOne,
    input wire logic comparatorTwo,
    input wire logic extIntPin,
    output logic bridgeOutA,
    output logic bridgeOutB,
    output logic bridgeOutC,
    output logic bridgeOutD,
    output logic bridgeOeA_n,
    output logic bridgeOeB_n,
    output logic bridgeOeC_n,
    output logic bridgeOeD_n,
    output logic irq
);
    // ****************************************************************
    // registers and state
    // ****************************************************************
    logic eventFlag_q;
    logic [2:0] srcSel_q;
    logic [1:0] pairAc_q;
    logic [1:0] pairBd_q;
    logic restartEn_q;
    logic [DELAY_WIDTH-1:0] delay_q;
    logic [7:0] duty_q;
    logic [7:0] period_q;
    logic [7:0] timer_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqMask_q;
    logic halted_q;
    logic [2:0] syncC1_q;
    logic [2:0] syncC2_q;
    logic [2:0] syncInt_q;
    logic c1_q;
    logic c2_q;
    logic intLow_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic tick;
    logic outA;
    logic outB;

    // ****************************************************************
    // input synchronisers: three stages, a change counts once 2 and 3 agree
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            syncC1_q <= 3'h0;
            syncC2_q <= 3'h0;
            syncInt_q <= 3'h7;
            c1_q <= 1'b0;
            c2_q <= 1'b0;
            intLow_q <= 1'b0;
        end
        else
        begin
            syncC1_q <= {syncC1_q[1:0], comparatorOne};
            syncC2_q <= {syncC2_q[1:0], comparatorTwo};
            syncInt_q <= {syncInt_q[1:0], extIntPin};
            if (syncC1_q[1] == syncC1_q[2])
                c1_q <= syncC1_q[2];
            if (syncC2_q[1] == syncC2_q[2])
                c2_q <= syncC2_q[2];
            if (syncInt_q[1] == syncInt_q[2])
                intLow_q <= ~syncInt_q[2];
        end
    end

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    wire access = psel & penable;
    wire wrEn = access & pwrite;
    wire known = hit(paddr, `ADDR_AUTO_SHUTDOWN_CONTROL)
        | hit(paddr, `ADDR_RESTART_DEADBAND_CONTROL) | hit(paddr, `ADDR_IRQ_STATUS)
        | hit(paddr, `ADDR_IRQ_MASK) | hit(paddr, `ADDR_PWM_DUTY)
        | hit(paddr, `ADDR_PWM_PERIOD);
    wire wrAsc = wrEn & hit(paddr, `ADDR_AUTO_SHUTDOWN_CONTROL);
    wire wrRdc = wrEn & hit(paddr, `ADDR_RESTART_DEADBAND_CONTROL);
    // enabled sources ORed, level sensitive
    wire condition = (srcSel_q[0] & c1_q) | (srcSel_q[1] & c2_q)
        | (srcSel_q[2] & intLow_q); // R02 R05
    wire swSet = wrAsc & pwdata[`FLD_EVENT_FLAG]; // R14
    wire swClear = wrAsc & ~pwdata[`FLD_EVENT_FLAG] & ~condition; // R06 R09
    wire hwClear = restartEn_q & ~condition; // R08
    wire periodEnd = (timer_q == period_q);
    wire shutActive = eventFlag_q | condition;
    wire [7:0] ascRead = {eventFlag_q, srcSel_q, pairAc_q, pairBd_q};
    wire [31:0] readMux =
        hit(paddr, `ADDR_AUTO_SHUTDOWN_CONTROL) ? {24'h0, ascRead} :
        hit(paddr, `ADDR_RESTART_DEADBAND_CONTROL) ? {24'h0, restartEn_q, delay_q} :
        hit(paddr, `ADDR_IRQ_STATUS) ? {30'h0, irqStat_q} :
        hit(paddr, `ADDR_IRQ_MASK) ? {30'h0, irqMask_q} :
        hit(paddr, `ADDR_PWM_DUTY) ? {24'h0, duty_q} :
        hit(paddr, `ADDR_PWM_PERIOD) ? {24'h0, period_q} : 32'h0;

    // ****************************************************************
    // shutdown flag: set wins over clear, writes ignored while condition holds
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
            eventFlag_q <= 1'b0;
        else if (condition || swSet)
            eventFlag_q <= 1'b1; // R01 R05 R14
        else if (swClear || hwClear)
            eventFlag_q <= 1'b0; // R08 R09
    end

    // restart waits for the period boundary, so no runt pulse leaves
    always_ff @(posedge clock)
    begin
        if (rst)
            halted_q <= 1'b1;
        else if (shutActive)
            halted_q <= 1'b1;
        else if (periodEnd && tick)
            halted_q <= 1'b0; // R07 only on the wrap tick, not mid-count
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            srcSel_q <= 3'(`RST_AUTO_SHUTDOWN_CONTROL >> `FLD_SRC_LO);
            pairAc_q <= 2'h0;
            pairBd_q <= 2'h0;
            restartEn_q <= 1'b0; // R12
            delay_q <= '0; // R12
            duty_q <= `RST_PWM_DUTY;
            period_q <= `RST_PWM_PERIOD;
            irqMask_q <= 2'h0;
        end
        else
        begin
            if (wrAsc)
            begin
                srcSel_q <= pwdata[`FLD_SRC_HI:`FLD_SRC_LO];
                pairAc_q <= pwdata[`FLD_AC_HI:`FLD_AC_LO];
                pairBd_q <= pwdata[`FLD_BD_HI:`FLD_BD_LO];
            end
            if (wrRdc)
            begin
                restartEn_q <= pwdata[`FLD_RESTART_EN]; // R12
                delay_q <= pwdata[DELAY_WIDTH-1:0];
            end
            if (wrEn && hit(paddr, `ADDR_PWM_DUTY))
                duty_q <= pwdata[7:0];
            if (wrEn && hit(paddr, `ADDR_PWM_PERIOD))
                period_q <= pwdata[7:0];
            if (wrEn && hit(paddr, `ADDR_IRQ_MASK))
                irqMask_q <= pwdata[1:0];
        end
    end

    // ****************************************************************
    // interrupts: bit0 shutdown entered, bit1 period end; write one clears
    // ****************************************************************
    wire [1:0] irqEvt = {periodEnd & tick, condition & ~eventFlag_q | swSet};
    wire [1:0] irqClr = (wrEn && hit(paddr, `ADDR_IRQ_STATUS)) ? pwdata[1:0] : 2'h0;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            irqStat_q <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            irqStat_q <= irqEvt | (irqStat_q & ~irqClr);
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ****************************************************************
    // period timer, stepping once per instruction cycle
    // ****************************************************************
    instr_tick u_tick
    (
        .clock(clock),
        .rst(rst),
        .tick(tick)
    );

    always_ff @(posedge clock)
    begin
        if (rst)
            timer_q <= 8'h0;
        else if (tick)
            timer_q <= periodEnd ? 8'h0 : timer_q + 8'h1;
    end

    // half-bridge: A is the PWM, B its complement, both edge-delayed
    wire schedA = ~halted_q & (timer_q < duty_q); // R16
    wire schedB = ~halted_q & ~(timer_q < duty_q); // R16

    deadband_delay #(.WIDTH(DELAY_WIDTH)) u_dbA
    (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .sched(schedA),
        .delay(delay_q),
        .actual(outA)
    );

    deadband_delay #(.WIDTH(DELAY_WIDTH)) u_dbB
    (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .sched(schedB),
        .delay(delay_q),
        .actual(outB)
    );

    // ****************************************************************
    // pins: condition forces shutdown state without waiting on the period
    // ****************************************************************
    wire acFloat = pairAc_q[1];
    wire bdFloat = pairBd_q[1];
    wire acLevel = pairAc_q[0];
    wire bdLevel = pairBd_q[0];
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bridgeOutA <= 1'b0;
            bridgeOutB <= 1'b0;
            bridgeOutC <= 1'b0;
            bridgeOutD <= 1'b0;
            bridgeOeA_n <= 1'b1;
            bridgeOeB_n <= 1'b1;
            bridgeOeC_n <= 1'b1;
            bridgeOeD_n <= 1'b1;
        end
        else if (shutActive || condition || swSet || halted_q)
        begin
            bridgeOutA <= acLevel; // R03 R13
            bridgeOutC <= acLevel; // R03
            bridgeOutB <= bdLevel; // R04 R13
            bridgeOutD <= bdLevel; // R04
            bridgeOeA_n <= acFloat;
            bridgeOeC_n <= acFloat;
            bridgeOeB_n <= bdFloat;
            bridgeOeD_n <= bdFloat;
        end
        else
        begin
            bridgeOutA <= outA & ~halted_q;
            bridgeOutB <= outB & ~halted_q;
            bridgeOutC <= 1'b0;
            bridgeOutD <= 1'b0;
            bridgeOeA_n <= 1'b0;
            bridgeOeB_n <= 1'b0;
            bridgeOeC_n <= 1'b0;
            bridgeOeD_n <= 1'b0;
        end
    end

    // ****************************************************************
    // APB slave: no wait states, unmapped addresses answer with pslverr
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~known;
            prdata_q <= readMux;
        end
    end
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_FLAG_HELD: assert property (@(posedge clock) disable iff (rst)
        condition |=> eventFlag_q) // R05
        else $error("flag clear while condition held");
    AST_WRITE_IGNORED: assert property (@(posedge clock) disable iff (rst)
        (condition && wrAsc && !pwdata[7]) |=> eventFlag_q) // R06
        else $error("flag cleared by write during condition");
    AST_AUTO_CLEAR: assert property (@(posedge clock) disable iff (rst)
        (restartEn_q && eventFlag_q && !condition && !swSet && !wrRdc) |=> !eventFlag_q) // R08
        else $error("auto restart did not clear flag");
    AST_NO_SELF_CLEAR: assert property (@(posedge clock) disable iff (rst)
        (!restartEn_q && eventFlag_q && !wrAsc && !wrRdc) |=> eventFlag_q) // R09
        else $error("flag cleared without software");
    AST_SW_EVENT: assert property (@(posedge clock) disable iff (rst)
        swSet |=> eventFlag_q) // R14
        else $error("software event missed");
    AST_PAIR_AC: assert property (@(posedge clock) disable iff (rst)
        (shutActive && !pairAc_q[1] && !wrAsc) |=> (bridgeOutA == $past(acLevel))
        && !bridgeOeC_n) // R03
        else $error("pair A/C wrong shutdown state");
    AST_PAIR_BD: assert property (@(posedge clock) disable iff (rst)
        (shutActive && pairBd_q[1] && !wrAsc) |=> bridgeOeB_n && bridgeOeD_n) // R04
        else $error("pair B/D not floating");
    AST_RESUME_BOUNDARY: assert property (@(posedge clock) disable iff (rst)
        $fell(halted_q) |-> $past(periodEnd)) // R07
        else $error("restart not at period start");
    AST_SHUT_FAST: assert property (@(posedge clock) disable iff (rst)
        $rose(condition) |=> (bridgeOeA_n == pairAc_q[1])) // R13
        else $error("pins late into shutdown");
    AST_RESET_ZERO: assert property (@(posedge clock)
        rst |=> !restartEn_q && delay_q == '0) // R12
        else $error("restart register not zero after reset");
    CV_SHUTDOWN: cover property (@(posedge clock) disable iff (rst) $rose(eventFlag_q));
    CV_AUTO: cover property (@(posedge clock) disable iff (rst)
        restartEn_q && $fell(eventFlag_q));
    CV_RESUME: cover property (@(posedge clock) disable iff (rst) $fell(halted_q));
endmodule : pwm_guard

/* File: logic/pwm_guard_consts.svh */
/*
 * Register offsets, field positions, reset values and timing counts for the
 * PWM shutdown, restart and dead-band block.
 * Assumes inclusion by bare name from the design modules and the testbench.
 */
`ifndef PWM_GUARD_CONSTS_SVH
`define PWM_GUARD_CONSTS_SVH

// ****************************************************************
// register map (byte addresses on the APB)
// ****************************************************************
`define ADDR_AUTO_SHUTDOWN_CONTROL 8'h00
`define ADDR_RESTART_DEADBAND_CONTROL 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0C
`define ADDR_PWM_DUTY 8'h10
`define ADDR_PWM_PERIOD 8'h14

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define FLD_EVENT_FLAG 7
`define FLD_SRC_HI 6
`define FLD_SRC_LO 4
`define FLD_AC_HI 3
`define FLD_AC_LO 2
`define FLD_BD_HI 1
`define FLD_BD_LO 0
`define FLD_RESTART_EN 7
`define RST_AUTO_SHUTDOWN_CONTROL 8'h00
`define RST_RESTART_DEADBAND_CONTROL 8'h00
`define RST_PWM_DUTY 8'h40
`define RST_PWM_PERIOD 8'hFF

// ****************************************************************
// timing: one instruction cycle is four oscillator periods
// ****************************************************************
`define OSC_PER_INSTR 4
`define OSC_PERIOD_NS 10
`define INSTR_PERIOD_NS (`OSC_PER_INSTR * `OSC_PERIOD_NS)
`define INSTR_CYCLES (`INSTR_PERIOD_NS / `OSC_PERIOD_NS)

`endif

/* File: logic/pwm_guard_pkg.sv */
/*
 * Types shared by the PWM guard block.
 * Assumes the constants header sits beside it.
 */
package pwm_guard_pkg;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        PAIR_DRIVE_LOW = 2'h0,
        PAIR_DRIVE_HIGH = 2'h1,
        PAIR_FLOAT = 2'h2
    } pairState_t;

    typedef enum logic [1:0]
    {
        DB_IDLE = 2'h0,
        DB_WAIT = 2'h1,
        DB_ACTIVE = 2'h3
    } deadbandState_t;
endpackage : pwm_guard_pkg

/* File: logic/instr_tick.sv */
/*
 * Instruction-cycle enable: one pulse every four clocks.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "pwm_guard_consts.svh"
module instr_tick
(
    input wire logic clock,
    input wire logic rst,
    output logic tick
);
    logic [1:0] div_q;

    // free-running divider
    always_ff @(posedge clock)
    begin
        if (rst)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end

    assign tick = (div_q == 2'(`INSTR_CYCLES - 1));
endmodule : instr_tick

/* File: logic/deadband_delay.sv */
/*
 * Dead-band delay for one output: holds off each inactive-to-active edge
 * by a count of instruction cycles; releases at once when falling.
 * Assumes tick is a one-cycle enable on the same clock.
 */
`timescale 1ns/100ps
`include "pwm_guard_consts.svh"
module deadband_delay
    import pwm_guard_pkg::*;
#(
    parameter int WIDTH = 7
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire logic sched,
    input wire logic [WIDTH-1:0] delay,
    output logic actual
);
    deadbandState_t state_q;
    deadbandState_t state_d;
    logic [WIDTH-1:0] cnt_q;
    logic sched_q;
    wire rise = sched & ~sched_q;
    wire done = (cnt_q >= delay);

    // next state: delay only the rising edge, fall at once
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            DB_IDLE: if (rise) state_d = (delay == '0) ? DB_ACTIVE : DB_WAIT;
            DB_WAIT: if (!sched) state_d = DB_IDLE; else if (done) state_d = DB_ACTIVE;
            DB_ACTIVE: if (!sched) state_d = DB_IDLE;
            default: state_d = DB_IDLE;
        endcase
    end

    // counter restarts on each scheduled rise, so a new delay applies next edge
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= DB_IDLE;
            cnt_q <= '0;
            sched_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            sched_q <= sched;
            if (rise)
                cnt_q <= '0; // R17
            else if (tick && state_q == DB_WAIT)
                cnt_q <= cnt_q + 1'b1; // R11
        end
    end

    // a delay longer than the duty leaves the output low all cycle
    assign actual = (state_q == DB_ACTIVE); // R10 R15

    AST_FALL_IMMEDIATE: assert property (@(posedge clock) disable iff (rst)
        !sched |=> !actual) // R10
        else $error("output stayed active after schedule fell");
endmodule : deadband_delay

/* File: testbench/pwm_bridge_load.sv */
/*
 * Far-side model: the half-bridge switch drivers that watch the four bridge pins.
 * Assumes a pull-down on every pin, so a released pin keeps its switch off.
 */
`timescale 1ns/100ps
module pwm_bridge_load
(
    input wire logic [3:0] drive,
    input wire logic [3:0] enableN,
    output logic [3:0] level
);
    // ****************************************************************
    // pin resolution
    // ****************************************************************
    // a floating pin reads as the pull-down level, never as the last driven value
    assign level = ~enableN & drive;
endmodule : pwm_bridge_load

/* File: testbench/tb_pwm_shutdown_restart_deadband.sv */
/*
 * Self-checking bench for the PWM guard: reset values, every shutdown source
 * and pair state, both restart paths, interrupt and half-bridge dead-band.
 * Assumes the design's APB slave answers within a few cycles.
 */
`timescale 1ns/100ps
`include "pwm_guard_consts.svh"
module tb_pwm_shutdown_restart_deadband import pwm_guard_pkg::*;;
    typedef struct packed {logic [2:0] src; logic [2:0] act; logic [1:0] ac; logic [1:0] bd;
        logic flag;} row_t;
    localparam logic [7:0] regShut = `ADDR_AUTO_SHUTDOWN_CONTROL;
    localparam logic [7:0] regRestart = `ADDR_RESTART_DEADBAND_CONTROL;
    localparam logic [7:0] regStatus = `ADDR_IRQ_STATUS;
    localparam logic [7:0] regMask = `ADDR_IRQ_MASK;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, err, irq;
    logic comparatorOne, comparatorTwo, extIntPin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    wire logic [3:0] drive;
    wire logic [3:0] enableN;
    logic [3:0] level;
    int numErrors = 0;
    int nCompared = 0;
    int cycles = 0;
    int n;
    row_t r;
    // source select, asserted sources {pin, two, one}, pair states, flag seen
    row_t rows [0:8] = '{'{3'h1, 3'h1, 2'h0, 2'h1, 1'h1}, '{3'h2, 3'h2, 2'h1, 2'h0, 1'h1},
        '{3'h3, 3'h2, 2'h2, 2'h3, 1'h1}, '{3'h4, 3'h4, 2'h3, 2'h2, 1'h1},
        '{3'h5, 3'h1, 2'h1, 2'h1, 1'h1}, '{3'h6, 3'h4, 2'h0, 2'h0, 1'h1},
        '{3'h7, 3'h2, 2'h2, 2'h1, 1'h1}, '{3'h0, 3'h7, 2'h1, 2'h1, 1'h0},
        '{3'h1, 3'h6, 2'h1, 2'h1, 1'h0}};

    pwm_guard dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparatorOne(comparatorOne), .comparatorTwo(comparatorTwo), .extIntPin(extIntPin),
        .bridgeOutA(drive[0]), .bridgeOutB(drive[1]), .bridgeOutC(drive[2]),
        .bridgeOutD(drive[3]), .bridgeOeA_n(enableN[0]), .bridgeOeB_n(enableN[1]),
        .bridgeOeC_n(enableN[2]), .bridgeOeD_n(enableN[3]), .irq(irq));
    pwm_bridge_load load (.drive(drive), .enableN(enableN), .level(level));

    // ****************************************************************
    // clock, timeout and helpers
    // ****************************************************************
    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    // cut a hang short well past the expected run length
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            numErrors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        nCompared++;
        if (seen !== expd)
        begin
            numErrors++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    // one APB transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (pready !== 1'h1) check(32'h0, 32'h1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] expd);
        apb(1'h0, a, 32'h0);
        check(rdata, expd);
    endtask : rd

    task automatic setSrc(input logic [2:0] act);
        comparatorOne <= act[0];
        comparatorTwo <= act[1];
        extIntPin <= ~act[2];
    endtask : setSrc

    // counts edges until a resolved pin reaches a level, or the limit runs out
    task automatic waitLevel(input int idx, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (level[idx] !== v && cnt < lim)
        begin
            @(posedge clock);
            cnt++;
        end
    endtask : waitLevel

    function automatic logic lv(input logic [1:0] st);
        return st == 2'h1;
    endfunction : lv

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rst = 1'h1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {comparatorOne, comparatorTwo, extIntPin} = 3'h1;
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        @(posedge clock);
        check({31'h0, irq}, 32'h0);
        rd(regShut, {24'h0, `RST_AUTO_SHUTDOWN_CONTROL});
        rd(regRestart, {24'h0, `RST_RESTART_DEADBAND_CONTROL});
        rd(8'h18, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'h1, regRestart, 32'hFF);
        rd(regRestart, 32'hFF);
        apb(1'h1, regRestart, 32'h0);
        $display("test reset and map done");
        // every source code and pair state, then a software restart
        foreach (rows[i])
        begin
            r = rows[i];
            apb(1'h1, regShut, {24'h0, 1'h0, r.src, r.ac, r.bd});
            setSrc(r.act);
            repeat (10) @(posedge clock);
            rd(regShut, {24'h0, r.flag, r.src, r.ac, r.bd});
            if (r.flag)
            begin
                check({28'h0, enableN}, {28'h0, r.bd[1], r.ac[1], r.bd[1], r.ac[1]});
                check({28'h0, level}, {28'h0, lv(r.bd), lv(r.ac), lv(r.bd), lv(r.ac)});
            end
            setSrc(3'h0);
            repeat (10) @(posedge clock);
            apb(1'h1, regShut, {24'h0, 1'h0, r.src, r.ac, r.bd});
            rd(regShut, {24'h0, 1'h0, r.src, r.ac, r.bd});
        end
        $display("test source table done");
        // clearing the flag while the source holds is ignored
        apb(1'h1, regShut, 32'h14);
        setSrc(3'h1);
        repeat (10) @(posedge clock);
        apb(1'h1, regShut, 32'h14);
        repeat (200) @(posedge clock);
        rd(regShut, 32'h94);
        check({31'h0, level[0]}, 32'h1);
        setSrc(3'h0);
        repeat (10) @(posedge clock);
        apb(1'h1, regShut, 32'h14);
        $display("test held source done");
        // hardware restart, period-aligned resume and the interrupt
        apb(1'h1, regRestart, 32'h80);
        apb(1'h1, regMask, 32'h3);
        apb(1'h1, regStatus, 32'h3);
        apb(1'h1, regShut, 32'h25);
        setSrc(3'h2);
        repeat (10) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        rd(regShut, 32'hA5);
        setSrc(3'h0);
        repeat (10) @(posedge clock);
        rd(regShut, 32'h25);
        check({31'h0, level[2]}, 32'h1);
        apb(1'h1, regStatus, 32'h2);
        waitLevel(2, 1'h0, 1100, n);
        check({31'h0, n < 1100}, 32'h1);
        rd(regStatus, 32'h3);
        apb(1'h1, regMask, 32'h0);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        apb(1'h1, regStatus, 32'h3);
        rd(regStatus, 32'h0);
        $display("test auto restart done");
        // a software-set flag is a shutdown event of its own
        apb(1'h1, regRestart, 32'h0);
        apb(1'h1, regShut, 32'h81);
        repeat (3) @(posedge clock);
        rd(regShut, 32'h81);
        check({30'h0, level[1], level[0]}, 32'h2);
        apb(1'h1, regShut, 32'h01);
        rd(regShut, 32'h01);
        $display("test software event done");
        // dead-band: each rising edge waits the count, falling edges do not
        apb(1'h1, `ADDR_PWM_PERIOD, 32'h1F);
        apb(1'h1, `ADDR_PWM_DUTY, 32'h10);
        for (int d = 3; d <= 9; d += 6)
        begin
            apb(1'h1, regRestart, 32'(d));
            waitLevel(1, 1'h0, 1200, n);
            waitLevel(0, 1'h1, 300, n);
            check({31'h0, n >= 4 * d - 3 && n <= 4 * d + 3}, 32'h1);
            waitLevel(0, 1'h0, 300, n);
            waitLevel(1, 1'h1, 300, n);
            check({31'h0, n >= 4 * d - 3 && n <= 4 * d + 3}, 32'h1);
        end
        // a count beyond the duty keeps the output idle
        apb(1'h1, regRestart, 32'h14);
        repeat (300) @(posedge clock);
        waitLevel(0, 1'h1, 400, n);
        check(32'(n), 32'd400);
        $display("test dead-band done");
        report_and_stop();
    end
endmodule : tb_pwm_shutdown_restart_deadband
